//--- design/port_b_gpio_alt_mux.sv
/*
 * Three-pin port: direction, pull-up and data registers behind an APB slave,
 * plus a fixed-priority mux handing pins to analog, timer, serial/LIN and PWM.
 * Assumes requesting modules and the bus share pclk; pin inputs pass a two-stage synchroniser.
 */
// The APB slave port was decided locally.
`timescale 1ns/10ps

module port_b_gpio_alt_mux
	import port_gpio_pkg::*;
(
	input  wire logic                                pclk,
	input  wire logic                                presetn,
	input  wire logic                                pclken,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [port_gpio_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic [port_gpio_pkg::APB_DATA_W-1:0] pwdata,
	output logic      [port_gpio_pkg::APB_DATA_W-1:0] prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire logic [port_gpio_pkg::PIN_COUNT-1:0]  pin_in,
	output logic      [port_gpio_pkg::PIN_COUNT-1:0]  pin_out,
	output logic      [port_gpio_pkg::PIN_COUNT-1:0]  pin_oe,
	output logic      [port_gpio_pkg::PIN_COUNT-1:0]  pin_pullup,
	input  wire logic [port_gpio_pkg::PIN_COUNT-1:0]  analog_sel,
	input  wire logic [port_gpio_pkg::PIN_COUNT-1:0]  timer_sel,
	input  wire logic [port_gpio_pkg::PIN_COUNT-1:0]  timer_oe,
	input  wire logic [port_gpio_pkg::PIN_COUNT-1:0]  timer_out,
	output logic      [port_gpio_pkg::PIN_COUNT-1:0]  timer_in,
	input  wire logic                                pwm_ch0,
	input  wire logic                                pwm_ch1,
	input  wire logic                                sci_txd,
	output logic                                     sci_rxd,
	input  wire logic                                lin_rxd,
	output logic                                     lin_txd
);
	import port_gpio_pkg::*;

	function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] addr,
		input logic [7:0] idx);
		reg_hit = (addr == {idx, 2'b00});
	endfunction : reg_hit

	logic [REG_W-1:0]     pullup_dir_q;
	logic [REG_W-1:0]     alt_route_q;
	logic [REG_W-1:0]     pin_data_q;
	logic [PIN_COUNT-1:0] pin_sync;

	// bus decode
	wire                  setup_phase  = psel & ~penable;
	wire                  access_done  = psel & penable & pready;
	wire                  wr_en        = access_done & pwrite;
	wire                  hit_pud      = reg_hit(paddr, IDX_PULLUP_DIR);
	wire                  hit_alt      = reg_hit(paddr, IDX_ALT_ROUTE);
	wire                  hit_data     = reg_hit(paddr, IDX_PIN_DATA);
	wire                  hit_any      = hit_pud | hit_alt | hit_data;

	// configuration fields
	wire [PIN_COUNT-1:0]  dir          = pullup_dir_q[DIR_LSB +: PIN_COUNT];
	wire [PIN_COUNT-1:0]  pup_en       = pullup_dir_q[PULLUP_LSB +: PIN_COUNT];
	wire                  pwm_route_en = alt_route_q[PWM_EN_BIT];
	wire                  pwm_chan_sel = alt_route_q[PWM_CS_BIT];
	ser_mode_type         ser_mode;
	assign ser_mode = ser_mode_type'(alt_route_q[SER_MODE_LSB +: 2]);

	// data read: output pins show the register, input pins the synced level
	wire [PIN_COUNT-1:0]  data_view    = (dir & pin_data_q[PIN_COUNT-1:0])
	                                   | (~dir & pin_sync);
	wire [REG_W-1:0]      rd_byte      = hit_pud  ? pullup_dir_q
	                                   : hit_alt  ? alt_route_q
	                                   : hit_data ? {{(REG_W-PIN_COUNT){1'b0}}, data_view}
	                                   : {REG_W{1'b0}};
	wire [APB_DATA_W-1:0] rd_word      = {{(APB_DATA_W-REG_W){1'b0}}, rd_byte};

	// serial routing per mode
	logic [1:0] ser_req;
	logic [1:0] ser_oe;
	logic [1:0] ser_out;
	logic       sci_rxd_d;
	logic       lin_txd_d;

	always_comb begin
		ser_req   = 2'b00;
		ser_oe    = 2'b00;
		ser_out   = {SER_IDLE, SER_IDLE};
		sci_rxd_d = SER_IDLE;
		lin_txd_d = SER_IDLE;
		case (ser_mode)
			SER_INTERNAL: begin
				// pins stay gpio
				sci_rxd_d = lin_rxd;
				lin_txd_d = sci_txd;
			end
			SER_EXT_SCI: begin
				ser_req           = 2'b11;
				sci_rxd_d         = pin_sync[RX_PIN];
				ser_oe[TX_PIN]    = 1'b1;
				ser_out[TX_PIN]   = sci_txd;
			end
			SER_EXT_LIN: begin
				ser_req           = 2'b11;
				ser_oe[RX_PIN]    = 1'b1;
				ser_out[RX_PIN]   = lin_rxd;
				lin_txd_d         = pin_sync[TX_PIN];
			end
			SER_OBSERVE: begin
				ser_req           = 2'b11;
				sci_rxd_d         = lin_rxd;
				lin_txd_d         = sci_txd;
				ser_oe            = 2'b11;
				ser_out[RX_PIN]   = lin_rxd;
				ser_out[TX_PIN]   = sci_txd;
			end
			default: begin
				ser_req = 2'b00;
			end
		endcase
	end

	// pwm routing onto pin two
	wire                  pwm_level    = pwm_chan_sel ? pwm_ch1 : pwm_ch0;
	wire [PIN_COUNT-1:0]  alt_req      = {pwm_route_en, ser_req};
	wire [PIN_COUNT-1:0]  alt_oe       = {1'b1, ser_oe};
	wire [PIN_COUNT-1:0]  alt_out      = {pwm_level, ser_out};

	// fixed priority: analog, then timer select lines, then the alt-route register bits claim the pins
	wire [PIN_COUNT-1:0]  analog_own   = analog_sel;
	wire [PIN_COUNT-1:0]  timer_own    = timer_sel & ~analog_sel;
	wire [PIN_COUNT-1:0]  alt_own      = alt_req & ~analog_sel & ~timer_sel;
	wire [PIN_COUNT-1:0]  gpio_own     = ~(analog_sel | timer_sel | alt_req);

	// analog owner leaves the driver off
	wire [PIN_COUNT-1:0]  pin_oe_d     = (gpio_own & dir)
	                                   | (timer_own & timer_oe)
	                                   | (alt_own & alt_oe);
	wire [PIN_COUNT-1:0]  pin_out_d    = (gpio_own & pin_data_q[PIN_COUNT-1:0])
	                                   | (timer_own & timer_out)
	                                   | (alt_own & alt_out);
	wire [PIN_COUNT-1:0]  pin_pullup_d = pup_en & ~pin_oe_d & ~analog_own;

	pin_sync #(
		.WIDTH (PIN_COUNT)
	) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pclken   (pclken),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);
	// timer sees the synchronised pin, same stage as the data read
	assign timer_in = pin_sync;

	// apb slave: answers one cycle after setup, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RDATA_ZERO;
		end else if (pclken) begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~hit_any;
			prdata  <= setup_phase ? rd_word : RDATA_ZERO;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_dir_q <= RST_PULLUP_DIR;
			alt_route_q  <= RST_ALT_ROUTE;
			pin_data_q   <= RST_PIN_DATA;
		end else if (pclken && wr_en) begin
			if (hit_pud)
				pullup_dir_q <= pwdata[REG_W-1:0] & MASK_PULLUP_DIR;
			if (hit_alt)
				alt_route_q  <= pwdata[REG_W-1:0] & MASK_ALT_ROUTE;
			if (hit_data)
				pin_data_q   <= pwdata[REG_W-1:0] & MASK_PIN_DATA;
		end
	end

	// pins and internal serial lines are registered to keep glitches off pads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out    <= '0;
			pin_oe     <= '0;
			pin_pullup <= '0;
			sci_rxd    <= SER_IDLE;
			lin_txd    <= SER_IDLE;
		end else if (pclken) begin
			pin_out    <= pin_out_d;
			pin_oe     <= pin_oe_d;
			pin_pullup <= pin_pullup_d;
			sci_rxd    <= sci_rxd_d;
			lin_txd    <= lin_txd_d;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence en_twice;
		pclken ##1 pclken;
	endsequence

	sequence read_data_setup;
		pclken && setup_phase && !pwrite && hit_data;
	endsequence

	a_pullup_never_out: assert property (
		(pin_oe & pin_pullup) == '0)
		else $error("pull-up active on a driven pin");

	a_analog_wins_pin: assert property (
		pclken |=> ((pin_oe & $past(analog_sel)) == '0)
		          && ((pin_pullup & $past(analog_sel)) == '0))
		else $error("analog-owned pin still driven or pulled");

	a_timer_drives_pin: assert property (
		pclken |=> ((pin_oe & $past(timer_own)) == $past(timer_oe & timer_own))
		          && ((pin_out & $past(timer_own)) == $past(timer_out & timer_own)))
		else $error("timer-owned pin not driven by the timer");

	a_gpio_direction: assert property (
		pclken |=> ((pin_oe & $past(gpio_own)) == $past(dir & gpio_own)))
		else $error("gpio pin enable differs from direction bit");

	a_gpio_pullup: assert property (
		pclken |=> ((pin_pullup & $past(gpio_own)) == $past(pup_en & ~dir & gpio_own)))
		else $error("gpio pull-up differs from its enable bit");

	a_pwm_on_pin: assert property (
		(pclken && pwm_route_en && alt_own[PWM_PIN])
		|=> pin_oe[PWM_PIN] && (pin_out[PWM_PIN] == $past(pwm_chan_sel ? pwm_ch1 : pwm_ch0)))
		else $error("selected pwm channel not on pin two");

	a_pwm_channel_sel: assert property (
		(pclken && pwm_route_en && alt_own[PWM_PIN] && pwm_chan_sel)
		|=> pin_out[PWM_PIN] == $past(pwm_ch1))
		else $error("pwm channel one not routed");

	a_read_data_view: assert property (
		read_data_setup |=> pready
		  && (prdata[PIN_COUNT-1:0] == $past((dir & pin_data_q[PIN_COUNT-1:0]) | (~dir & pin_sync))))
		else $error("data read mixes register and pin wrongly");

	a_sync_two_stage: assert property (
		en_twice |=> (timer_in == $past(pin_in, 2)))
		else $error("pin input not delayed by two stages");

	a_mode_internal: assert property (
		(pclken && ser_mode == SER_INTERNAL)
		|=> (sci_rxd == $past(lin_rxd)) && (lin_txd == $past(sci_txd))
		    && ((pin_oe[1:0] & $past(gpio_own[1:0])) == $past(dir[1:0] & gpio_own[1:0])))
		else $error("internal serial link broken");

	a_mode_ext_sci: assert property (
		(pclken && ser_mode == SER_EXT_SCI && alt_own[TX_PIN])
		|=> pin_oe[TX_PIN] && (pin_out[TX_PIN] == $past(sci_txd))
		    && (sci_rxd == $past(pin_sync[RX_PIN])) && lin_txd)
		else $error("external serial routing wrong");

	a_mode_ext_lin: assert property (
		(pclken && ser_mode == SER_EXT_LIN && alt_own[RX_PIN])
		|=> pin_oe[RX_PIN] && (pin_out[RX_PIN] == $past(lin_rxd))
		    && (lin_txd == $past(pin_sync[TX_PIN])) && sci_rxd)
		else $error("external lin routing wrong");

	a_mode_observe: assert property (
		(pclken && ser_mode == SER_OBSERVE && alt_own[1:0] == 2'b11)
		|=> (pin_oe[1:0] == 2'b11) && (pin_out[TX_PIN] == $past(sci_txd))
		    && (pin_out[RX_PIN] == $past(lin_rxd)) && (lin_txd == $past(sci_txd)))
		else $error("observe mode mirror wrong");

	a_ready_after_setup: assert property (
		(pclken && setup_phase) |=> pready && (pslverr == !$past(hit_any)))
		else $error("setup not answered in the next cycle");

	a_pwm_off_pin: assert property (
		(pclken && !pwm_route_en && gpio_own[PWM_PIN])
		|=> (pin_oe[PWM_PIN] == $past(dir[PWM_PIN]))
		    && (pin_out[PWM_PIN] == $past(pin_data_q[PWM_PIN])))
		else $error("pin two carries pwm while routing is off");

	a_enable_freeze: assert property (
		!pclken |=> $stable(timer_in) && $stable(pin_oe) && $stable(pin_out)
		            && $stable(pready))
		else $error("state moved while the clock enable was low");

	a_data_write_mask: assert property (
		(pclken && wr_en && hit_data)
		|=> (pin_data_q == $past(pwdata[REG_W-1:0] & MASK_PIN_DATA)))
		else $error("data register write lost or unmasked");

endmodule : port_b_gpio_alt_mux

//--- design/port_gpio_pkg.sv
/*
 * Shared constants for the three-pin port with alternate-function routing:
 * register indices, field positions, reset values and the serial route modes.
 * Assumes a 32-bit APB master whose byte address is four times the index.
 */
package port_gpio_pkg;

	localparam int          PIN_COUNT      = 3;
	localparam int          APB_ADDR_W     = 10;
	localparam int          APB_DATA_W     = 32;
	localparam int          REG_W          = 8;

	// register indices; byte address is index times four
	localparam logic [7:0]  IDX_PULLUP_DIR = 8'h20;
	localparam logic [7:0]  IDX_ALT_ROUTE  = 8'h21;
	localparam logic [7:0]  IDX_PIN_DATA   = 8'h22;

	// field positions
	localparam int          DIR_LSB        = 0;
	localparam int          PULLUP_LSB     = 4;
	localparam int          SER_MODE_LSB   = 0;
	localparam int          PWM_EN_BIT     = 2;
	localparam int          PWM_CS_BIT     = 3;
	localparam int          PWM_PIN        = 2;
	localparam int          RX_PIN         = 0;
	localparam int          TX_PIN         = 1;

	// writable bits and reset values
	localparam logic [7:0]  MASK_PULLUP_DIR = 8'h77;
	localparam logic [7:0]  MASK_ALT_ROUTE  = 8'h0F;
	localparam logic [7:0]  MASK_PIN_DATA   = 8'h07;
	localparam logic [7:0]  RST_PULLUP_DIR  = 8'h00;
	localparam logic [7:0]  RST_ALT_ROUTE   = 8'h00;
	localparam logic [7:0]  RST_PIN_DATA    = 8'h00;

	// idle level of serial lines that are cut off
	localparam logic        SER_IDLE        = 1'b1;
	localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

	typedef enum logic [1:0] {
		SER_INTERNAL = 2'b00,
		SER_EXT_SCI  = 2'b01,
		SER_EXT_LIN  = 2'b10,
		SER_OBSERVE  = 2'b11
	} ser_mode_type;

endpackage : port_gpio_pkg

//--- design/pin_sync.sv
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes a single clock; the first stage feeds nothing but the second.
 */
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             pclken,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else if (pclken) begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : pin_sync

//--- verif/pin_env.sv
/*
 * Pad environment of the port: resolves each pad from the port drive,
 * its pull-up and an optional outside driver. Assumes one clock, pclk.
 */
`timescale 1ns/10ps
module pin_env (
	input  wire logic       pclk,
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe,
	input  wire logic [2:0] pin_pullup,
	input  wire logic [2:0] ext_en,
	input  wire logic [2:0] ext_val,
	output logic      [2:0] pin_in
);
	logic [2:0] float_q;

	// a floating pad wanders, so it never reads as a steady level
	initial float_q = 3'h5;
	always @(posedge pclk) float_q <= ~float_q;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
				pin_pullup[i] ? 1'b1 : float_q[i];
		end
	end
endmodule : pin_env

//--- verif/tb_port_b_gpio_alt_mux.sv
/*
 * Self-checking bench for the three-pin port: a cycle model predicts every
 * pin, serial line and APB answer. Assumes pin_env drives the pads.
 */
`timescale 1ns/10ps
module tb_port_b_gpio_alt_mux;
	import port_gpio_pkg::*;
	localparam logic [9:0] A_PD = {IDX_PULLUP_DIR, 2'b00};
	localparam logic [9:0] A_AR = {IDX_ALT_ROUTE, 2'b00};
	localparam logic [9:0] A_DT = {IDX_PIN_DATA, 2'b00};
	localparam logic [9:0] ADDRS [4] = '{A_PD, A_AR, A_DT, 10'h3FC};
	logic        pclk, presetn, pclken, psel, penable, pwrite, pready, pslverr;
	logic        pwm_ch0, pwm_ch1, sci_txd, sci_rxd, lin_rxd, lin_txd, rnd_on, rnd_pce;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, seed, rv, e_rd, e_prd;
	logic [2:0]  pin_in, pin_out, pin_oe, pin_pullup, analog_sel, timer_sel, timer_oe;
	logic [2:0]  timer_out, timer_in, ext_en, ext_val, sy1_q, sy2_q, e_oe, e_out, e_pu, e_tin;
	logic [7:0]  pud_q, alt_q, dat_q;
	logic [1:0]  m;
	logic        e_rxd, e_txd, c_rxd, c_txd, e_err, oe, ov, pu, e_rdy, e_psl;
	int          fails, cmp_count;

	port_b_gpio_alt_mux port_b_gpio_alt_mux_i (.*);
	pin_env pin_env_i (.*);

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// one idle edge first, so back-to-back calls never assign psel twice
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			fails++;
		chk("pslverr", {31'h0, e_err}, {31'h0, pslverr});
		if (!wr)
			chk("prdata", e_rd, prdata);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	always @(posedge pclk) begin
		if (rnd_on) begin
			rv = rnd();
			analog_sel <= rv[2:0] & rv[5:3];
			timer_sel <= rv[8:6];
			timer_oe <= rv[11:9];
			timer_out <= rv[14:12];
			{pwm_ch0, pwm_ch1, sci_txd, lin_rxd} <= rv[18:15];
			ext_en <= rv[21:19];
			ext_val <= rv[24:22];
			pclken <= rnd_pce ? rv[27:25] != 3'h0 : 1'b1;
		end
	end

	// model: outputs from the registers as they stood before the edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{pud_q, alt_q, dat_q, sy1_q, sy2_q} = '0;
			{e_oe, e_out, e_pu, e_tin, e_rxd, e_txd, c_rxd, c_txd} = 16'h000F;
			{e_rdy, e_psl, e_prd} = '0;
		end else if (pclken) begin
			m = alt_q[1:0];
			for (int i = 0; i < 3; i++) begin
				oe = pud_q[i];
				ov = dat_q[i];
				if (i == 2 && alt_q[2]) begin
					oe = 1'b1;
					ov = alt_q[3] ? pwm_ch1 : pwm_ch0;
				end
				if (i < 2 && m != 2'b00) begin
					oe = (i == 0) ? m[1] : m[0];
					ov = (i == 0) ? lin_rxd : sci_txd;
				end
				if (timer_sel[i]) begin
					oe = timer_oe[i];
					ov = timer_out[i];
				end
				pu = pud_q[4 + i] & ~oe;
				if (analog_sel[i]) begin
					oe = 1'b0;
					pu = 1'b0;
				end
				e_oe[i] = oe;
				e_out[i] = ov;
				e_pu[i] = pu;
			end
			// synced pin feeds are judged only on a steady pin
			c_rxd = m != 2'b01 || (pin_in[0] == sy1_q[0] && sy1_q[0] == sy2_q[0]);
			c_txd = m != 2'b10 || (pin_in[1] == sy1_q[1] && sy1_q[1] == sy2_q[1]);
			e_rxd = m == 2'b01 ? sy2_q[0] : m == 2'b10 ? 1'b1 : lin_rxd;
			e_txd = m == 2'b10 ? sy2_q[1] : m == 2'b01 ? 1'b1 : sci_txd;
			if (psel && !penable) begin
				e_err = !(paddr inside {A_PD, A_AR, A_DT});
				e_rd = '0;
				if (paddr == A_PD)
					e_rd[7:0] = pud_q;
				if (paddr == A_AR)
					e_rd[7:0] = alt_q;
				if (paddr == A_DT)
					e_rd[2:0] = (dat_q[2:0] & pud_q[2:0]) | (sy2_q & ~pud_q[2:0]);
			end
			// write lands on the model's own answer, not the design's pready
			if (psel && penable && e_rdy && pwrite) begin
				if (paddr == A_PD)
					pud_q = pwdata[7:0] & MASK_PULLUP_DIR;
				if (paddr == A_AR)
					alt_q = pwdata[7:0] & MASK_ALT_ROUTE;
				if (paddr == A_DT)
					dat_q = pwdata[7:0] & MASK_PIN_DATA;
			end
			e_rdy = psel && !penable;
			e_psl = e_rdy && e_err;
			e_prd = e_rdy ? e_rd : '0;
			sy2_q = sy1_q;
			sy1_q = pin_in;
			e_tin = sy2_q;
		end
	end

	always @(negedge pclk) begin
		if (presetn) begin
			chk("pin_oe", e_oe, pin_oe);
			chk("pin_out", e_out & e_oe, pin_out & e_oe);
			chk("pin_pullup", e_pu, pin_pullup);
			chk("timer_in", e_tin, timer_in);
			chk("pready", {31'h0, e_rdy}, {31'h0, pready});
			chk("pslverr_line", {31'h0, e_psl}, {31'h0, pslverr});
			chk("prdata_line", e_prd, prdata);
			if (c_rxd)
				chk("sci_rxd", e_rxd, sci_rxd);
			if (c_txd)
				chk("lin_txd", e_txd, lin_txd);
		end
	end

	initial begin
		#1_000_000;
		fails++;
		print_verdict();
	end

	initial begin
		seed = 32'd93599;
		presetn = 1'b0;
		pclken = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = '0;
		pwdata = '0;
		{analog_sel, timer_sel, timer_oe, timer_out} = '0;
		{pwm_ch0, pwm_ch1, sci_txd, lin_rxd} = 4'h3;
		ext_en = 3'h7;
		ext_val = 3'h5;
		{rnd_on, rnd_pce} = 2'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, write masks, unmapped slot
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, ADDRS[k], 32'h0);
			apb(1'b1, ADDRS[k], 32'hFFFF_FFFF);
			apb(1'b0, ADDRS[k], 32'h0);
		end
		ext_val <= 3'h2;
		apb(1'b1, A_AR, 32'h0);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, A_PD, k ? 32'h72 : 32'h75);
			apb(1'b1, A_DT, 32'h5);
			repeat (3) @(posedge pclk);
			apb(1'b0, A_DT, 32'h0);
		end
		rnd_on <= 1'b1;
		for (int j = 0; j < 64; j++) begin
			apb(1'b1, A_AR, 32'(j % 16));
			apb(1'b1, A_PD, rnd());
			apb(1'b1, A_DT, rnd());
			rnd_pce <= (j % 2 == 1);
			repeat (30) @(posedge pclk);
			rnd_pce <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		rnd_on <= 1'b0;
		repeat (4) @(posedge pclk);
		// reset in mid-run: registers and syncs must fall back to reset values
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 4; k++)
			apb(1'b0, ADDRS[k], 32'h0);
		repeat (4) @(posedge pclk);
		print_verdict();
	end
endmodule : tb_port_b_gpio_alt_mux
